// *** shared/psiu_pkg.sv ***
/*
   Constants, encodings and carrier types of the program counter, return stack and
   indirect addressing unit.
   Assumes one core clock domain shared by the instruction decoder and this unit.
*/
package psiu_pkg;

   // ====================
   // widths
   localparam int PC_W        = 13;
   localparam int PCL_W       = 8;
   localparam int PCH_W       = 5;
   localparam int TARGET_W    = 11;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W        = 3;
   localparam int DATA_W      = 8;
   localparam int FILE_AW     = 9;
   localparam int AXI_AW      = 8;
   localparam int AXI_DW      = 32;

   // ====================
   // reset values
   localparam logic [PC_W-1:0]   PC_RESET     = 13'h0000;
   localparam logic [PC_W-1:0]   IRQ_VECTOR   = 13'h0004;
   localparam logic [PCH_W-1:0]  LATCH_RESET  = 5'h00;
   localparam logic [DATA_W-1:0] PTR_RESET    = 8'h00;
   localparam logic [SP_W-1:0]   SP_RESET     = 3'h0;
   localparam logic [DATA_W-1:0] WINDOW_READ  = 8'h00;

   // ====================
   // file addresses, low seven bits, mirrored in every bank
   localparam logic [6:0] FA_WINDOW = 7'h00;
   localparam logic [6:0] FA_PCL    = 7'h02;
   localparam logic [6:0] FA_STATUS = 7'h03;
   localparam logic [6:0] FA_PTR    = 7'h04;
   localparam logic [6:0] FA_LATCH  = 7'h0A;
   localparam int         STATUS_BANK_POS = 7;
   localparam int         LATCH_JUMP_LO   = 3;

   // ====================
   // register bus byte offsets
   localparam logic [AXI_AW-1:0] RA_PCL   = 8'h00;
   localparam logic [AXI_AW-1:0] RA_LATCH = 8'h04;
   localparam logic [AXI_AW-1:0] RA_PTR   = 8'h08;
   localparam logic [AXI_AW-1:0] RA_BANK  = 8'h0C;
   localparam int                BANK_POS = 0;
   localparam logic [1:0]        RESP_OKAY   = 2'h0;
   localparam logic [1:0]        RESP_SLVERR = 2'h2;

   // ====================
   // sequencing operations from the decoder
   typedef enum logic [7:0] {
      OP_NONE    = 8'h01,
      OP_STEP    = 8'h02,
      OP_JUMP    = 8'h04,
      OP_CALL    = 8'h08,
      OP_RET     = 8'h10,
      OP_RET_LIT = 8'h20,
      OP_RET_INT = 8'h40,
      OP_IRQ     = 8'h80
   } psiu_op_t;

   typedef struct packed {
      psiu_op_t              op;
      logic [TARGET_W-1:0]   target;
   } psiu_seq_req_t;

   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic [FILE_AW-1:0]    addr;
      logic [DATA_W-1:0]     wdata;
   } psiu_file_req_t;

endpackage : psiu_pkg

// *** core/psiu_stack_mem.sv ***
/*
   Return stack storage: a small word memory with registered read data and
   write-through when the word being written is the one being read.
   Assumes the caller supplies the next top-of-stack index every cycle.
*/
module psiu_stack_mem #(
   parameter int DEPTH = psiu_pkg::STACK_DEPTH,
   parameter int WIDTH = psiu_pkg::PC_W,
   parameter int AW    = psiu_pkg::SP_W
) (
   input  wire logic             aclk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);

   // ====================
   // elaboration check
   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("stack depth must equal two to the index width");
   end

   // ====================
   // storage
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (we && (waddr == raddr)) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule : psiu_stack_mem

// *** core/psiu_top.sv ***
/*
   Program counter, circular return stack and indirect data addressing of the core,
   with software access over an AXI4-Lite slave.
   Assumes decoder requests arrive one per cycle on aclk and the data memory sits
   outside, fed by the registered indirect access port.
*/
// What this block does
// - Keep a 13-bit program counter; low byte is a readable, writable register.
// - Upper five counter bits are hidden; writes reach them only through the high latch.
// - Every reset clears the whole program counter.
// - Writing the low byte loads high bits from latch bits 4..0 together.
// - Call and jump take the top two counter bits from latch bits 4..3.
// - Return stack holds eight 13-bit entries outside program and data space.
// - The stack pointer cannot be read or written by software.
// - Call or interrupt vectoring pushes the program counter.
// - Return, return with literal and interrupt return pop into the counter.
// - Pushes and pops leave the high latch unchanged.
// - The stack wraps: the ninth push overwrites the first entry.
// - No overflow or underflow indication exists.
// - Accessing the window register accesses the location the pointer selects.
// - Indirect read of the window itself returns 00h.
// - Indirect write of the window itself stores nothing.
// - Indirect address is the bank bit above the 8-bit pointer.
module psiu_top #(
   parameter logic [psiu_pkg::PC_W-1:0] IRQ_VEC = psiu_pkg::IRQ_VECTOR
) (
   input  wire logic                              aclk,
   input  wire logic                              aresetn,
   input  wire logic                              core_reset,
   input  wire psiu_pkg::psiu_seq_req_t           seq_req,
   input  wire psiu_pkg::psiu_file_req_t          file_req,
   output logic     [psiu_pkg::PC_W-1:0]          pc,
   output logic     [psiu_pkg::DATA_W-1:0]        loc_rdata,
   output logic                                   loc_rvalid,
   output psiu_pkg::psiu_file_req_t               ind_acc,
   input  wire logic [psiu_pkg::AXI_AW-1:0]       s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [psiu_pkg::AXI_DW-1:0]       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic     [1:0]                         s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [psiu_pkg::AXI_AW-1:0]       s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic     [psiu_pkg::AXI_DW-1:0]        s_axi_rdata,
   output logic     [1:0]                         s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready
);

   // ====================
   // helpers
   function automatic logic is_window(input logic [6:0] a);
      is_window = (a == psiu_pkg::FA_WINDOW);
   endfunction : is_window

   function automatic logic is_local(input logic [6:0] a);
      is_local = (a == psiu_pkg::FA_PCL) || (a == psiu_pkg::FA_STATUS) ||
                 (a == psiu_pkg::FA_PTR) || (a == psiu_pkg::FA_LATCH);
   endfunction : is_local

   function automatic logic is_mapped(input logic [psiu_pkg::AXI_AW-1:0] a);
      is_mapped = (a == psiu_pkg::RA_PCL) || (a == psiu_pkg::RA_LATCH) ||
                  (a == psiu_pkg::RA_PTR) || (a == psiu_pkg::RA_BANK);
   endfunction : is_mapped

   // ====================
   // state
   logic [psiu_pkg::PCH_W-1:0]   pc_high_latch;
   logic [psiu_pkg::DATA_W-1:0]  pointer_reg;
   logic                         bank_pointer_bit;
   logic [psiu_pkg::SP_W-1:0]    sp;
   logic [psiu_pkg::SP_W-1:0]    next_sp;
   logic [psiu_pkg::PC_W-1:0]    next_pc;
   logic [psiu_pkg::PC_W-1:0]    stack_top;
   logic                         push;
   logic                         pop;
   logic                         branch;

   // ====================
   // register bus write side
   logic                         aw_full;
   logic                         w_full;
   logic [psiu_pkg::AXI_AW-1:0]  aw_addr;
   logic [psiu_pkg::DATA_W-1:0]  w_byte;
   logic                         w_lane;
   logic                         aw_take;
   logic                         w_take;
   logic                         wr_fire;
   logic                         next_aw_full;
   logic                         next_w_full;
   logic                         ar_take;
   logic                         next_rvalid;
   assign aw_take      = s_axi_awvalid && s_axi_awready;
   assign w_take       = s_axi_wvalid && s_axi_wready;
   assign wr_fire      = aw_full && w_full && !s_axi_bvalid;
   assign next_aw_full = (aw_full && !wr_fire) || aw_take;
   assign next_w_full  = (w_full && !wr_fire) || w_take;
   assign ar_take      = s_axi_arvalid && s_axi_arready;
   assign next_rvalid  = ar_take || (s_axi_rvalid && !s_axi_rready);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_addr       <= '0;
         w_byte        <= '0;
         w_lane        <= 1'b0;
      end else begin
         aw_full       <= next_aw_full;
         w_full        <= next_w_full;
         s_axi_awready <= !next_aw_full;
         s_axi_wready  <= !next_w_full;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_byte <= s_axi_wdata[psiu_pkg::DATA_W-1:0];
            w_lane <= s_axi_wstrb[0];
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= psiu_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(aw_addr) ? psiu_pkg::RESP_OKAY : psiu_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ====================
   // register bus read side; no stack pointer or high counter bits are mapped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= psiu_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= psiu_pkg::RESP_OKAY;
            case (s_axi_araddr)
               psiu_pkg::RA_PCL:   s_axi_rdata[psiu_pkg::PCL_W-1:0] <= pc[psiu_pkg::PCL_W-1:0];
               psiu_pkg::RA_LATCH: s_axi_rdata[psiu_pkg::PCH_W-1:0] <= pc_high_latch;
               psiu_pkg::RA_PTR:   s_axi_rdata[psiu_pkg::DATA_W-1:0] <= pointer_reg;
               psiu_pkg::RA_BANK:  s_axi_rdata[psiu_pkg::BANK_POS] <= bank_pointer_bit;
               default:            s_axi_rresp <= psiu_pkg::RESP_SLVERR;
            endcase
         end
      end
   end

   // ====================
   // file access decode: window redirect through the pointer
   logic                         dir_win;
   logic [psiu_pkg::FILE_AW-1:0] eff_addr;
   logic                         eff_null;
   logic                         eff_loc;
   logic                         f_wr;
   logic                         bus_wr;
   always_comb begin
      dir_win  = is_window(file_req.addr[6:0]);
      eff_addr = dir_win ? {bank_pointer_bit, pointer_reg} : file_req.addr;
      eff_null = dir_win && is_window(pointer_reg[6:0]);
      eff_loc  = !eff_null && is_local(eff_addr[6:0]);
   end
   assign f_wr   = file_req.wr && eff_loc;
   assign bus_wr = wr_fire && w_lane;

   // ====================
   // low byte write detection, decoder wins over the bus
   logic                         pcl_wr;
   logic [psiu_pkg::PCL_W-1:0]   pcl_data;
   always_comb begin
      pcl_wr   = 1'b0;
      pcl_data = w_byte;
      if (f_wr && (eff_addr[6:0] == psiu_pkg::FA_PCL)) begin
         pcl_wr   = 1'b1;
         pcl_data = file_req.wdata;
      end else if (bus_wr && (aw_addr == psiu_pkg::RA_PCL)) begin
         pcl_wr   = 1'b1;
      end
   end

   // ====================
   // program counter sequencing
   always_comb begin
      push    = 1'b0;
      pop     = 1'b0;
      branch  = 1'b1;
      next_pc = pc;
      case (seq_req.op)
         psiu_pkg::OP_STEP: begin
            branch  = 1'b0;
            next_pc = pc + 13'h0001;
         end
         psiu_pkg::OP_JUMP: begin
            next_pc = {pc_high_latch[psiu_pkg::PCH_W-1:psiu_pkg::LATCH_JUMP_LO],
                       seq_req.target};
         end
         psiu_pkg::OP_CALL: begin
            push    = 1'b1;
            next_pc = {pc_high_latch[psiu_pkg::PCH_W-1:psiu_pkg::LATCH_JUMP_LO],
                       seq_req.target};
         end
         psiu_pkg::OP_RET, psiu_pkg::OP_RET_LIT, psiu_pkg::OP_RET_INT: begin
            pop     = 1'b1;
            next_pc = stack_top;
         end
         psiu_pkg::OP_IRQ: begin
            push    = 1'b1;
            next_pc = IRQ_VEC;
         end
         default: begin
            branch  = 1'b0;
         end
      endcase
      if (pcl_wr && !branch) begin
         next_pc = {pc_high_latch, pcl_data};
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || core_reset) begin
         pc <= psiu_pkg::PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // ====================
   // circular return stack, pointer wraps silently
   always_comb begin
      next_sp = sp;
      if (push) begin
         next_sp = sp + 3'h1;
      end else if (pop) begin
         next_sp = sp - 3'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp <= psiu_pkg::SP_RESET;
      end else begin
         sp <= next_sp;
      end
   end
   psiu_stack_mem #(
      .DEPTH (psiu_pkg::STACK_DEPTH),
      .WIDTH (psiu_pkg::PC_W),
      .AW    (psiu_pkg::SP_W)
   ) u_stack (
      .aclk  (aclk),
      .we    (push),
      .waddr (sp),
      .wdata (pc),
      .raddr (next_sp - 3'h1),
      .rdata (stack_top)
   );

   // ====================
   // latch, pointer and bank bit; decoder writes land after bus writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_high_latch    <= psiu_pkg::LATCH_RESET;
         pointer_reg      <= psiu_pkg::PTR_RESET;
         bank_pointer_bit <= 1'b0;
      end else begin
         if (bus_wr && (aw_addr == psiu_pkg::RA_LATCH)) begin
            pc_high_latch <= w_byte[psiu_pkg::PCH_W-1:0];
         end
         if (bus_wr && (aw_addr == psiu_pkg::RA_PTR)) begin
            pointer_reg <= w_byte;
         end
         if (bus_wr && (aw_addr == psiu_pkg::RA_BANK)) begin
            bank_pointer_bit <= w_byte[psiu_pkg::BANK_POS];
         end
         if (f_wr && (eff_addr[6:0] == psiu_pkg::FA_LATCH)) begin
            pc_high_latch <= file_req.wdata[psiu_pkg::PCH_W-1:0];
         end
         if (f_wr && (eff_addr[6:0] == psiu_pkg::FA_PTR)) begin
            pointer_reg <= file_req.wdata;
         end
         if (f_wr && (eff_addr[6:0] == psiu_pkg::FA_STATUS)) begin
            bank_pointer_bit <= file_req.wdata[psiu_pkg::STATUS_BANK_POS];
         end
      end
   end

   // ====================
   // local read answers and the outgoing data memory access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loc_rvalid <= 1'b0;
         loc_rdata  <= '0;
      end else begin
         loc_rvalid <= file_req.rd && (eff_null || eff_loc);
         loc_rdata  <= '0;
         if (file_req.rd && eff_null) begin
            loc_rdata <= psiu_pkg::WINDOW_READ;
         end else if (file_req.rd && eff_loc) begin
            case (eff_addr[6:0])
               psiu_pkg::FA_PCL:    loc_rdata <= pc[psiu_pkg::PCL_W-1:0];
               psiu_pkg::FA_LATCH:  loc_rdata <= {3'h0, pc_high_latch};
               psiu_pkg::FA_PTR:    loc_rdata <= pointer_reg;
               psiu_pkg::FA_STATUS: loc_rdata[psiu_pkg::STATUS_BANK_POS] <= bank_pointer_bit;
               default:             loc_rdata <= '0;
            endcase
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ind_acc <= '0;
      end else begin
         ind_acc.rd    <= file_req.rd && !eff_null && !eff_loc;
         ind_acc.wr    <= file_req.wr && !eff_null && !eff_loc;
         ind_acc.addr  <= eff_addr;
         ind_acc.wdata <= file_req.wdata;
      end
   end

endmodule : psiu_top

// *** verification/psiu_checker.sv ***
/*
   checker: port timing relations of the sequencing unit.
   assumes one aclk domain, sync active-low aresetn; bound below.
*/
module psiu_checker #(
   parameter logic [12:0] IRQ_VEC = 13'h0004
) (
   input wire logic                     aclk,
   input wire logic                     aresetn,
   input wire logic                     core_reset,
   input wire psiu_pkg::psiu_seq_req_t  seq_req,
   input wire psiu_pkg::psiu_file_req_t file_req,
   input wire logic [12:0]              pc,
   input wire logic [7:0]               loc_rdata,
   input wire logic                     loc_rvalid,
   input wire psiu_pkg::psiu_file_req_t ind_acc,
   input wire logic [7:0]               s_axi_araddr,
   input wire logic                     s_axi_arvalid,
   input wire logic                     s_axi_arready,
   input wire logic [1:0]               s_axi_rresp,
   input wire logic                     s_axi_rvalid,
   input wire logic                     s_axi_bvalid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ====================
   // sequences
   sequence s_quiet;
      !core_reset && !file_req.wr;
   endsequence
   sequence s_call_ret;
      seq_req.op == psiu_pkg::OP_CALL && !core_reset ##1
      seq_req.op == psiu_pkg::OP_RET && !core_reset;
   endsequence
   // ====================
   // properties
   property p_clear;
      core_reset |=> pc == 13'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("pc not cleared");
   property p_step;
      seq_req.op == psiu_pkg::OP_STEP ##0 s_quiet
         |=> pc == $past(pc) + 13'h0001 || $rose(s_axi_bvalid);
   endproperty
   a_step: assert property (p_step) else $error("step wrong");
   property p_branch;
      (seq_req.op == psiu_pkg::OP_JUMP || seq_req.op == psiu_pkg::OP_CALL) && !core_reset
         |=> pc[10:0] == $past(seq_req.target);
   endproperty
   a_branch: assert property (p_branch) else $error("branch target wrong");
   property p_call_ret;
      s_call_ret |=> pc == $past(pc, 2);
   endproperty
   a_call_ret: assert property (p_call_ret) else $error("return address wrong");
   property p_irq;
      seq_req.op == psiu_pkg::OP_IRQ && !core_reset |=> pc == IRQ_VEC;
   endproperty
   a_irq: assert property (p_irq) else $error("vector wrong");
   property p_pcl;
      file_req.wr && file_req.addr[6:0] == psiu_pkg::FA_PCL
         && seq_req.op == psiu_pkg::OP_NONE && !core_reset
         |=> pc[7:0] == $past(file_req.wdata);
   endproperty
   a_pcl: assert property (p_pcl) else $error("low byte write lost");
   property p_window;
      file_req.rd && file_req.addr[6:0] == psiu_pkg::FA_WINDOW |=> ind_acc.rd != loc_rvalid;
   endproperty
   a_window: assert property (p_window) else $error("window read unanswered");
   property p_null;
      ind_acc.rd || ind_acc.wr |-> ind_acc.addr[6:0] != 7'h00;
   endproperty
   a_null: assert property (p_null) else $error("window reached itself");
   property p_null_rd;
      loc_rvalid && ind_acc.addr[6:0] == psiu_pkg::FA_WINDOW |-> loc_rdata == 8'h00;
   endproperty
   a_null_rd: assert property (p_null_rd) else $error("null read not zero");
   property p_no_sp;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > psiu_pkg::RA_BANK
         |=> s_axi_rvalid && s_axi_rresp == psiu_pkg::RESP_SLVERR;
   endproperty
   a_no_sp: assert property (p_no_sp) else $error("hidden state readable");
endmodule : psiu_checker

bind psiu_top psiu_checker #(.IRQ_VEC(IRQ_VEC)) u_psiu_checker (
   .aclk(aclk), .aresetn(aresetn), .core_reset(core_reset), .seq_req(seq_req),
   .file_req(file_req), .pc(pc), .loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid),
   .ind_acc(ind_acc), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid));

// *** verification/psiu_dec_model.sv ***
/*
   decoder partner model: drives sequencing and file requests.
   assumes one aclk domain; each request holds until the next call.
*/
module psiu_dec_model (
   input  wire logic                aclk,
   output psiu_pkg::psiu_seq_req_t  seq_req,
   output psiu_pkg::psiu_file_req_t file_req
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      seq_req  = '{psiu_pkg::OP_NONE, 11'h000};
      file_req = '0;
   end
   // ====================
   // one request per edge
   task automatic issue(input psiu_pkg::psiu_op_t op, input logic [10:0] t,
                        input psiu_pkg::psiu_file_req_t f);
      @(posedge aclk);
      seq_req  <= '{op, t};
      file_req <= f;
   endtask : issue
   // computed jump: software carries into the latch itself
   task automatic cjump(input logic [12:0] base, input logic [7:0] off);
      logic [12:0] tgt;
      tgt = base + 13'(off);
      issue(psiu_pkg::OP_NONE, 11'h000, '{1'b0, 1'b1, 9'h00A, {3'h0, tgt[12:8]}});
      issue(psiu_pkg::OP_NONE, 11'h000, '{1'b0, 1'b1, 9'h002, tgt[7:0]});
   endtask : cjump
endmodule : psiu_dec_model

// *** verification/tb_top.sv ***
/*
   testbench of the sequencing unit: bus, decoder and window scenarios.
   assumes psiu_top, the decoder model and the bound checker.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                     aclk = 1'b0, aresetn = 1'b0, core_reset = 1'b0;
   psiu_pkg::psiu_seq_req_t  seq_req;
   psiu_pkg::psiu_file_req_t file_req, ind_acc;
   logic [12:0]              pc;
   logic [7:0]               loc_rdata, s_axi_awaddr = '0, s_axi_araddr = '0;
   logic                     loc_rvalid, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic                     s_axi_arready, s_axi_rvalid;
   logic                     s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic                     s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0]              s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]               s_axi_wstrb = 4'hF;
   logic [1:0]               s_axi_bresp, s_axi_rresp;
   int                       err_total = 0, n_tests = 0, cyc = 0;
   always #50 aclk = ~aclk;
   psiu_dec_model u_psiu_dec_model (.aclk(aclk), .seq_req(seq_req), .file_req(file_req));
   psiu_top u_psiu_top (
      .aclk(aclk), .aresetn(aresetn), .core_reset(core_reset), .seq_req(seq_req),
      .file_req(file_req), .pc(pc), .loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid),
      .ind_acc(ind_acc), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   // ====================
   // helpers
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk("bresp", s_axi_bresp, er);
      s_axi_bready <= 1'b0;
      #1;
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk("rdata", s_axi_rdata, ed);
      chk("rresp", s_axi_rresp, er);
      s_axi_rready <= 1'b0;
      #1;
   endtask : axr
   task automatic op1(input psiu_pkg::psiu_op_t op, input logic [10:0] t,
                      input psiu_pkg::psiu_file_req_t f);
      u_psiu_dec_model.issue(op, t, f);
      u_psiu_dec_model.issue(psiu_pkg::OP_NONE, 11'h000, '0);
      #1;
   endtask : op1
   // ====================
   // scenarios
   task automatic t_reset();
      chk("pc", pc, 13'h0000);
      axr(psiu_pkg::RA_LATCH, 32'h0, psiu_pkg::RESP_OKAY);
      op1(psiu_pkg::OP_JUMP, 11'h155, '0);
      @(posedge aclk) core_reset <= 1'b1;
      @(posedge aclk) core_reset <= 1'b0;
      #1 chk("pc", pc, 13'h0000);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_bus();
      axw(psiu_pkg::RA_LATCH, 32'h15, 4'hF, psiu_pkg::RESP_OKAY);
      axw(psiu_pkg::RA_PCL, 32'h34, 4'hF, psiu_pkg::RESP_OKAY);
      chk("pc", pc, 13'h1534);
      op1(psiu_pkg::OP_STEP, 11'h000, '0);
      chk("pc", pc, 13'h1535);
      axw(psiu_pkg::RA_PCL, 32'h77, 4'h0, psiu_pkg::RESP_OKAY);
      axr(psiu_pkg::RA_PCL, 32'h35, psiu_pkg::RESP_OKAY);
      axr(8'h10, 32'h0, psiu_pkg::RESP_SLVERR);
      axw(8'h10, 32'h1, 4'hF, psiu_pkg::RESP_SLVERR);
      $display("t_bus done");
   endtask : t_bus
   task automatic t_branch();
      op1(psiu_pkg::OP_NONE, 11'h000, '{1'b0, 1'b1, 9'h00A, 8'h18});
      op1(psiu_pkg::OP_JUMP, 11'h123, '0);
      chk("pc", pc, 13'h1923);
      u_psiu_dec_model.issue(psiu_pkg::OP_CALL, 11'h055, '0);
      op1(psiu_pkg::OP_RET, 11'h000, '0);
      chk("pc", pc, 13'h1923);
      op1(psiu_pkg::OP_IRQ, 11'h000, '0);
      chk("pc", pc, psiu_pkg::IRQ_VECTOR);
      op1(psiu_pkg::OP_RET_INT, 11'h000, '0);
      chk("pc", pc, 13'h1923);
      $display("t_branch done");
   endtask : t_branch
   task automatic t_stack();
      for (int i = 0; i < 9; i++) u_psiu_dec_model.issue(psiu_pkg::OP_CALL, 11'(9'h100 + i), '0);
      for (int k = 8; k > 0; k--) begin
         op1((k % 2) ? psiu_pkg::OP_RET : psiu_pkg::OP_RET_LIT, 11'h000, '0);
         chk("pc", pc, 13'h1900 + 13'(k - 1));
      end
      op1(psiu_pkg::OP_RET, 11'h000, '0);
      chk("pc", pc, 13'h1907);
      axr(psiu_pkg::RA_LATCH, 32'h18, psiu_pkg::RESP_OKAY);
      $display("t_stack done");
   endtask : t_stack
   task automatic t_ind();
      axw(psiu_pkg::RA_PTR, 32'h45, 4'hF, psiu_pkg::RESP_OKAY);
      axw(psiu_pkg::RA_BANK, 32'h1, 4'hF, psiu_pkg::RESP_OKAY);
      op1(psiu_pkg::OP_NONE, 11'h000, '{1'b1, 1'b0, 9'h000, 8'h00});
      chk("ind", {ind_acc.rd, ind_acc.addr}, {1'b1, 9'h145});
      op1(psiu_pkg::OP_NONE, 11'h000, '{1'b0, 1'b1, 9'h080, 8'hA5});
      chk("ind", {ind_acc.wr, ind_acc.addr, ind_acc.wdata}, {1'b1, 9'h145, 8'hA5});
      op1(psiu_pkg::OP_NONE, 11'h000, '{1'b1, 1'b0, 9'h003, 8'h00});
      chk("stat", loc_rdata, 8'h80);
      axw(psiu_pkg::RA_PTR, 32'h80, 4'hF, psiu_pkg::RESP_OKAY);
      axw(psiu_pkg::RA_BANK, 32'h0, 4'hF, psiu_pkg::RESP_OKAY);
      op1(psiu_pkg::OP_NONE, 11'h000, '{1'b1, 1'b0, 9'h000, 8'h00});
      chk("null", {ind_acc.rd, loc_rvalid, loc_rdata}, {2'h1, 8'h00});
      op1(psiu_pkg::OP_NONE, 11'h000, '{1'b0, 1'b1, 9'h000, 8'h5A});
      chk("nowr", ind_acc.wr, 1'b0);
      u_psiu_dec_model.cjump(13'h01F0, 8'h20);
      op1(psiu_pkg::OP_NONE, 11'h000, '0);
      chk("pc", pc, 13'h0210);
      $display("t_ind done");
   endtask : t_ind
   // ====================
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      t_reset();
      t_bus();
      t_branch();
      t_stack();
      t_ind();
      test_done();
   end
endmodule : tb_top
